// File: logic/card_access_defines.svh
// Timing constants and the overview of the removable media access control
// Overview of operation
// - Button held one second requests access stop
// - Indicator blinks during stop, dark after
// - Indicator blinks while preparing, then steady
// - Stop waits for running card function
// - Prohibit flag ignores button, indicator lit
// - Forced-disable request stops access, ignores prohibit
// - Request changes ignored until status follows
// - Status flag set, indicator dark when stopped
// - Insertion keeps indicator off while disabled
// - Comment/initial-value access finishes, later raises error
// - Tool, messaging, transfer server get errors
// - File instruction completes, later ones error
// - Backup stops after file, records cause
// - Sensor backup completes, later gets error
// - Transfer client stops after file, errors
// - Cassette change erases device/label memory
// - Cassette-present flag set when recognised
// - Capacity mismatch blinks error indicator only
`ifndef CARD_ACCESS_DEFINES_SVH
`define CARD_ACCESS_DEFINES_SVH
`define CLOCK_HZ 50000000
`define BUTTON_HOLD_MS 1000
`define BUTTON_HOLD_CYCLES ((`CLOCK_HZ / 1000) * `BUTTON_HOLD_MS)
`define BLINK_HALF_MS 250
`define BLINK_HALF_CYCLES ((`CLOCK_HZ / 1000) * `BLINK_HALF_MS)
`define PREPARE_MS 100
`define PREPARE_CYCLES ((`CLOCK_HZ / 1000) * `PREPARE_MS)
`define ERR_NONE 4'h0
`define ERR_DISABLED_DURING 4'h1
`define ERR_DISABLED_AFTER 4'h2
`endif

// File: logic/card_access_pkg.sv
// Types shared by the removable media access control
package card_access_pkg;
   typedef enum logic [2:0]
   {
      CARD_EMPTY = 3'b000,
      CARD_PREPARE = 3'b001,
      CARD_READY = 3'b010,
      CARD_STOPPING = 3'b011,
      CARD_STOPPED = 3'b100
   } card_state_e;
endpackage : card_access_pkg

// File: logic/pin_sync.sv
// Three-stage pin synchroniser with agreement filter
module pin_sync
(
   input wire logic clock,
   input wire logic reset,
   input wire logic pinIn,
   output logic pinOut
);
   // Stage registers; first stage is read only by the second
   logic s1_r;
   logic s2_r;
   logic s3_r;
   logic out_r;

   // Level accepted only when second and third stage agree
   always_ff @(posedge clock)
   begin
      if (reset)
      begin
         s1_r <= 1'b0;
         s2_r <= 1'b0;
         s3_r <= 1'b0;
         out_r <= 1'b0;
      end
      else
      begin
         s1_r <= pinIn;
         s2_r <= s1_r;
         s3_r <= s2_r;
         if (s2_r == s3_r)
         begin
            out_r <= s3_r;
         end
      end
   end

   assign pinOut = out_r;
endmodule : pin_sync

// File: logic/removable_media_access_control.sv
// Card access stop control and extended memory cassette reporting
`include "card_access_defines.svh"
module removable_media_access_control
   import card_access_pkg::*;
#(
   parameter int unsigned HOLD_CYCLES = `BUTTON_HOLD_CYCLES,
   parameter int unsigned BLINK_CYCLES = `BLINK_HALF_CYCLES,
   parameter int unsigned PREP_CYCLES = `PREPARE_CYCLES
)
(
   input wire logic clock,
   input wire logic reset,
   input wire logic cardOffButton,
   input wire logic cardDetect,
   input wire logic removeInsertProhibit,
   input wire logic forcedDisableRequest,
   output logic forcedDisableStatus,
   output logic cardReadyIndicator,
   output logic cardAccessEnable,
   input wire logic commentBusy,
   input wire logic commentReq,
   output logic commentError,
   input wire logic remoteReq,
   output logic remoteError,
   input wire logic fileInstrBusy,
   input wire logic fileInstrReq,
   output logic fileInstrError,
   input wire logic backupBusy,
   input wire logic backupFileDone,
   input wire logic backupReq,
   output logic backupAbort,
   output logic [3:0] backupErrorCause,
   input wire logic sensorBackupBusy,
   input wire logic sensorBackupReq,
   output logic sensorBackupError,
   input wire logic transferBusy,
   input wire logic transferFileDone,
   input wire logic transferReq,
   output logic transferAbort,
   output logic [3:0] transferStatus,
   input wire logic cassetteDetect,
   input wire logic capacityMismatch,
   output logic cassettePresentFlag,
   output logic deviceMemoryErase,
   output logic errorIndicator
);
   // Synchronised pin levels
   // Each pin passes four flops, since none of them is on this clock
   logic buttonSync;
   logic cardSync;
   logic cassetteSync;

   pin_sync buttonSyncInst
   (
      .clock(clock),
      .reset(reset),
      .pinIn(cardOffButton),
      .pinOut(buttonSync)
   );

   pin_sync cardSyncInst
   (
      .clock(clock),
      .reset(reset),
      .pinIn(cardDetect),
      .pinOut(cardSync)
   );

   pin_sync cassetteSyncInst
   (
      .clock(clock),
      .reset(reset),
      .pinIn(cassetteDetect),
      .pinOut(cassetteSync)
   );

   // All state of the block except the three pin synchronisers in one record
   typedef struct packed
   {
      card_state_e state;
      logic [31:0] holdCount;
      logic [31:0] blinkCount;
      logic [31:0] prepCount;
      logic blink;
      logic disStatus;
      logic reqSeen;
      logic stickyOff;
      logic cassettePrev;
      logic cassetteFlag;
      logic cassetteSeen;
      logic [2:0] settleCount; // Edges since reset, saturating at seven
      logic erase;
      logic commentErr;
      logic remoteErr;
      logic fileErr;
      logic backupAbt;
      logic [3:0] backupCause;
      logic sensorErr;
      logic transferAbt;
      logic [3:0] transferStat;
      logic errBlink;
   } ctl_s;

   ctl_s ctl_r;
   ctl_s ctl_nxt;

   // Any whole-job function (comment, file instruction, sensor backup) still in flight
   logic finishBusy;
   // Stop may complete only when file-granular jobs reach a file boundary
   logic backupIdle;
   logic transferIdle;
   // Stop lands this cycle, so the status flag can rise with it
   logic stopNow;

   assign backupIdle = !backupBusy || backupFileDone;
   assign transferIdle = !transferBusy || transferFileDone;
   assign finishBusy = commentBusy || fileInstrBusy || sensorBackupBusy;

   // Next-state logic for the whole block
   always_comb
   begin
      ctl_nxt = ctl_r;
      ctl_nxt.erase = 1'b0;
      ctl_nxt.commentErr = 1'b0;
      ctl_nxt.remoteErr = 1'b0;
      ctl_nxt.fileErr = 1'b0;
      ctl_nxt.backupAbt = 1'b0;
      ctl_nxt.sensorErr = 1'b0;
      ctl_nxt.transferAbt = 1'b0;
      stopNow = 1'b0;

      // Free-running blink phase shared by both indicators
      // One shared counter keeps both lamps in step, the registered error lamp one cycle behind, at the cost of a 32-bit register
      if (ctl_r.blinkCount >= BLINK_CYCLES - 1)
      begin
         ctl_nxt.blinkCount = 32'h0;
         ctl_nxt.blink = !ctl_r.blink;
      end
      else
      begin
         ctl_nxt.blinkCount = ctl_r.blinkCount + 32'h1;
      end

      // Hold timer for the stop button; prohibit masks it entirely
      // The count saturates, so a very long press cannot wrap and re-arm
      if (buttonSync && !removeInsertProhibit)
      begin
         if (ctl_r.holdCount < HOLD_CYCLES)
         begin
            ctl_nxt.holdCount = ctl_r.holdCount + 32'h1;
         end
      end
      else
      begin
         ctl_nxt.holdCount = 32'h0;
      end

      // Request edges only count once status has caught up
      // A change made before status follows is dropped, not queued
      if (forcedDisableRequest != ctl_r.reqSeen && ctl_r.reqSeen == ctl_r.disStatus)
      begin
         ctl_nxt.reqSeen = forcedDisableRequest;
      end

      case (ctl_r.state)
         CARD_EMPTY:
         begin
            // A card arriving while disabled goes dark at once, with no blink
            if (cardSync && (ctl_r.reqSeen || ctl_r.disStatus || ctl_r.stickyOff))
            begin
               ctl_nxt.state = CARD_STOPPED;
            end
            // Card seen: prepare it from a fresh count
            else if (cardSync)
            begin
               ctl_nxt.state = CARD_PREPARE;
               ctl_nxt.prepCount = 32'h0;
            end
         end
         CARD_PREPARE:
         begin
            // Card pulled mid-prepare goes back to empty
            if (!cardSync)
            begin
               ctl_nxt.state = CARD_EMPTY;
            end
            else if (ctl_r.reqSeen || ctl_r.disStatus || ctl_r.stickyOff)
            begin
               ctl_nxt.state = CARD_STOPPED;
            end
            else if (ctl_r.prepCount >= PREP_CYCLES - 1)
            begin
               ctl_nxt.state = CARD_READY;
            end
            else
            begin
               ctl_nxt.prepCount = ctl_r.prepCount + 32'h1;
            end
         end
         CARD_READY:
         begin
            // The forced request outranks the button; both lead to stopping
            if (!cardSync)
            begin
               ctl_nxt.state = CARD_EMPTY;
            end
            else if (ctl_r.reqSeen)
            begin
               ctl_nxt.state = CARD_STOPPING;
            end
            else if (ctl_r.holdCount >= HOLD_CYCLES)
            begin
               ctl_nxt.state = CARD_STOPPING;
               ctl_nxt.stickyOff = 1'b1;
            end
         end
         CARD_STOPPING:
         begin
            // Abort file-granular jobs at their next file boundary
            if (backupBusy && backupFileDone)
            begin
               ctl_nxt.backupAbt = 1'b1;
               ctl_nxt.backupCause = `ERR_DISABLED_DURING;
            end
            if (transferBusy && transferFileDone)
            begin
               ctl_nxt.transferAbt = 1'b1;
               ctl_nxt.transferStat = `ERR_DISABLED_DURING;
            end
            // Whole-job functions finish first, so stop latency follows the slowest one
            if (!finishBusy && backupIdle && transferIdle)
            begin
               stopNow = 1'b1;
               ctl_nxt.state = CARD_STOPPED;
            end
         end
         CARD_STOPPED:
         begin
            // Removing the card with no request or status pending brings the slot back to empty
            if (!cardSync && !ctl_r.reqSeen && !ctl_r.disStatus)
            begin
               ctl_nxt.state = CARD_EMPTY;
            end
         end
         // Unused codes fall back to the empty slot
         default:
         begin
            ctl_nxt.state = CARD_EMPTY;
         end
      endcase

      // Status flag follows the accepted request once the stop lands
      if (ctl_r.reqSeen && !ctl_r.disStatus && (stopNow || ctl_r.state == CARD_STOPPED
          || ctl_r.state == CARD_EMPTY))
      begin
         ctl_nxt.disStatus = 1'b1;
      end
      else if (!ctl_r.reqSeen && ctl_r.disStatus)
      begin
         // Clearing the request also forgets an earlier button stop
         ctl_nxt.disStatus = 1'b0;
         ctl_nxt.stickyOff = 1'b0;
      end

      // Requests to a stopping or stopped card are refused with errors; a backup request only records its cause, with no abort pulse
      // Remote access is refused even while stopping; the others are waited for
      if (ctl_r.state == CARD_STOPPING || ctl_r.state == CARD_STOPPED || ctl_r.state == CARD_EMPTY)
      begin
         ctl_nxt.commentErr = commentReq && ctl_r.state != CARD_STOPPING;
         ctl_nxt.remoteErr = remoteReq;
         ctl_nxt.fileErr = fileInstrReq && ctl_r.state != CARD_STOPPING;
         ctl_nxt.sensorErr = sensorBackupReq && ctl_r.state != CARD_STOPPING;
         if (backupReq && ctl_r.state != CARD_STOPPING)
         begin
            ctl_nxt.backupCause = `ERR_DISABLED_AFTER;
         end
         if (transferReq && ctl_r.state != CARD_STOPPING)
         begin
            ctl_nxt.transferAbt = 1'b1;
            ctl_nxt.transferStat = `ERR_DISABLED_AFTER;
         end
      end

      // Cassette tracking: the level held once the synchroniser has settled counts as recognised
      // The synchronisers read zero for a few edges after reset, so a cassette fitted at power-on
      // would otherwise look like a fresh insertion and wipe the memory
      ctl_nxt.cassettePrev = cassetteSync;
      if (ctl_r.settleCount != 3'h7)
      begin
         ctl_nxt.settleCount = ctl_r.settleCount + 3'h1;
      end
      ctl_nxt.cassetteSeen = (ctl_r.settleCount == 3'h7);
      ctl_nxt.cassetteFlag = cassetteSync;
      if (ctl_r.cassetteSeen && cassetteSync != ctl_r.cassettePrev)
      begin
         ctl_nxt.erase = 1'b1;
      end

      // Mismatch shows as a blinking error lamp with no recorded error
      // Limitation: only the lamp tells; nothing is recorded for firmware to read
      ctl_nxt.errBlink = capacityMismatch && cassetteSync && ctl_r.blink;
   end

   // Register the whole record
   // Synchronous reset clears everything, the blink phase included
   always_ff @(posedge clock)
   begin
      if (reset)
      begin
         ctl_r <= '0;
      end
      else
      begin
         ctl_r <= ctl_nxt;
      end
   end

   // Indicator: blink while preparing or stopping, off with no card
   // Decoded straight from the state register, so it adds no lag
   always_comb
   begin
      case (ctl_r.state)
         CARD_PREPARE: cardReadyIndicator = ctl_r.blink;
         CARD_READY: cardReadyIndicator = 1'b1;
         CARD_STOPPING: cardReadyIndicator = ctl_r.blink;
         CARD_STOPPED: cardReadyIndicator = 1'b0;
         default: cardReadyIndicator = 1'b0;
      endcase
   end

   // Access stays granted while stopping so running jobs can finish
   assign cardAccessEnable = (ctl_r.state == CARD_READY) || (ctl_r.state == CARD_STOPPING);
   // Flags and error pulses come straight from the record
   assign forcedDisableStatus = ctl_r.disStatus;
   assign commentError = ctl_r.commentErr;
   assign remoteError = ctl_r.remoteErr;
   assign fileInstrError = ctl_r.fileErr;
   assign backupAbort = ctl_r.backupAbt;
   assign backupErrorCause = ctl_r.backupCause;
   assign sensorBackupError = ctl_r.sensorErr;
   assign transferAbort = ctl_r.transferAbt;
   assign transferStatus = ctl_r.transferStat;
   assign cassettePresentFlag = ctl_r.cassetteFlag;
   assign deviceMemoryErase = ctl_r.erase;
   assign errorIndicator = ctl_r.errBlink;
endmodule : removable_media_access_control

// File: tb/rmac_sva.sv
// Assertion checker for the card access control block
module rmac_sva
(
   input wire logic clock,
   input wire logic reset,
   input wire logic cardDetect,
   input wire logic removeInsertProhibit,
   input wire logic forcedDisableRequest,
   input wire logic forcedDisableStatus,
   input wire logic cardReadyIndicator,
   input wire logic cardAccessEnable,
   input wire logic commentBusy,
   input wire logic commentReq,
   input wire logic commentError,
   input wire logic remoteReq,
   input wire logic remoteError,
   input wire logic fileInstrBusy,
   input wire logic fileInstrReq,
   input wire logic fileInstrError,
   input wire logic backupBusy,
   input wire logic sensorBackupBusy,
   input wire logic transferBusy,
   input wire logic cassetteDetect,
   input wire logic deviceMemoryErase
);
   // One clock domain, so clock and reset are given once
   default clocking @(posedge clock);
   endclocking
   default disable iff (reset);
   // No card-using function holds the stop back
   sequence s_quiet;
      !(commentBusy || fileInstrBusy || sensorBackupBusy || backupBusy || transferBusy);
   endsequence
   // A fresh request while usable, followed by quiet cycles
   sequence s_stop_req;
      $rose(forcedDisableRequest) && cardAccessEnable && cardDetect ##0 s_quiet [*4];
   endsequence
   a_force_stops: assert property (s_stop_req |-> ##[0:3] forcedDisableStatus)
      else $error("forced stop did not complete");
   a_busy_holds: assert property (fileInstrBusy && cardAccessEnable && cardDetect |=> cardAccessEnable)
      else $error("access dropped under a running instruction");
   a_prohibit_lit: assert property (removeInsertProhibit && cardAccessEnable && cardReadyIndicator && cardDetect
      && !forcedDisableRequest && !forcedDisableStatus |=> cardReadyIndicator || !cardDetect)
      else $error("indicator changed while prohibited");
   a_comment_err: assert property (commentReq && forcedDisableStatus |=> commentError)
      else $error("late comment access not refused");
   a_remote_err: assert property (remoteReq && forcedDisableStatus |=> remoteError)
      else $error("late remote access not refused");
   a_file_err: assert property ($past(fileInstrReq) && $past(forcedDisableStatus) |-> fileInstrError)
      else $error("late file instruction not refused");
   a_no_card: assert property (!cardDetect [*8] |-> !cardReadyIndicator)
      else $error("indicator lit with empty slot");
   a_status_dark: assert property (forcedDisableStatus |-> !cardReadyIndicator && !cardAccessEnable)
      else $error("stopped yet indicator or access on");
   a_cassette_erase: assert property ($rose(cassetteDetect) |-> ##[1:8] deviceMemoryErase)
      else $error("no erase on cassette change");
endmodule : rmac_sva
bind removable_media_access_control rmac_sva chk (.clock, .reset, .cardDetect, .removeInsertProhibit,
   .forcedDisableRequest, .forcedDisableStatus, .cardReadyIndicator, .cardAccessEnable, .commentBusy, .commentReq,
   .commentError, .remoteReq, .remoteError, .fileInstrBusy, .fileInstrReq, .fileInstrError, .backupBusy,
   .sensorBackupBusy, .transferBusy, .cassetteDetect, .deviceMemoryErase);

// File: tb/card_model.sv
// Behavioural card slot and file-instruction partner
module card_model
(
   input wire logic clock,
   input wire logic reset,
   input wire logic insert,
   input wire logic startJob,
   output logic cardDetect,
   output logic jobBusy
);
   timeunit 1ns;
   timeprecision 1ps;
   int left; // Cycles left in the running job
   // Slot contact follows the card at once
   assign cardDetect = insert;
   // A job runs its full length; the stop may not cut it short
   always_ff @(posedge clock)
   begin
      if (reset)
         left <= 0;
      else if (startJob)
         left <= 50;
      else if (left > 0)
         left <= left - 1;
   end
   assign jobBusy = (left > 0);
endmodule : card_model

// File: tb/testbench.sv
// Self-checking bench for the card access control block
`include "card_access_defines.svh"
module testbench;
   timeunit 1ns;
   timeprecision 1ps;
   logic clock = 1'h0;
   logic reset = 1'h1;
   logic cardOffButton = 1'h0;
   logic removeInsertProhibit = 1'h0;
   logic forcedDisableRequest = 1'h0;
   logic cassetteDetect = 1'h0;
   logic insert = 1'h0;
   logic startJob = 1'h0;
   logic backupBusy = 1'h0;
   logic backupFileDone = 1'h0;
   logic transferBusy = 1'h0;
   logic transferFileDone = 1'h0;
   logic capacityMismatch = 1'h0;
   logic [5:0] req = 6'h00; // comment remote file backup sensor transfer
   logic [5:0] err;
   logic cardDetect, fileInstrBusy, forcedDisableStatus, cardReadyIndicator, cardAccessEnable;
   logic cassettePresentFlag, deviceMemoryErase, errorIndicator;
   logic [3:0] backupErrorCause, transferStatus;
   int n_mismatch = 0;
   int comparisons = 0;
   int highs, lows; // Indicator samples, to see blinking
   int nErase = 0; // Erase pulses seen
   // Erase pulses are counted mid-cycle, where the registered pulse is settled
   always @(negedge clock)
      if (deviceMemoryErase === 1'h1)
         nErase <= nErase + 1;
   // Short counts keep the run small
   removable_media_access_control #(.HOLD_CYCLES(20), .BLINK_CYCLES(4), .PREP_CYCLES(8)) uut (.clock, .reset,
      .cardOffButton, .cardDetect, .removeInsertProhibit, .forcedDisableRequest, .forcedDisableStatus,
      .cardReadyIndicator, .cardAccessEnable, .commentBusy(1'h0), .commentReq(req[5]), .commentError(err[5]),
      .remoteReq(req[4]), .remoteError(err[4]), .fileInstrBusy, .fileInstrReq(req[3]), .fileInstrError(err[3]),
      .backupBusy, .backupFileDone, .backupReq(req[2]), .backupAbort(err[2]), .backupErrorCause,
      .sensorBackupBusy(1'h0), .sensorBackupReq(req[1]), .sensorBackupError(err[1]), .transferBusy,
      .transferFileDone, .transferReq(req[0]), .transferAbort(err[0]), .transferStatus, .cassetteDetect,
      .capacityMismatch, .cassettePresentFlag, .deviceMemoryErase, .errorIndicator);
   card_model partner (.clock, .reset, .insert, .startJob, .cardDetect, .jobBusy(fileInstrBusy));
   // Free-running clock
   always #10 clock = ~clock;
   task automatic print_verdict();
      if (n_mismatch == 0 && comparisons > 0)
         $display("ALL TESTS PASSED");
      else
         $display("TESTS FAILED");
      $finish;
   endtask : print_verdict
   task automatic check(input logic ok, input string m);
      comparisons++;
      if (ok !== 1'h1)
      begin
         n_mismatch++;
         $display("BAD %0t %s", $time, m);
      end
   endtask : check
   // Sample after each edge has settled
   task automatic hold(input int n);
      repeat (n)
      begin
         @(posedge clock);
         #1;
         if (cardReadyIndicator === 1'h1)
            highs++;
         else
            lows++;
      end
   endtask : hold
   function automatic logic cond(input int k);
      case (k)
         0: return cardAccessEnable;
         1: return !cardAccessEnable;
         2: return forcedDisableStatus;
         3: return !forcedDisableStatus;
         5: return !cassettePresentFlag;
         default: return cassettePresentFlag;
      endcase
   endfunction : cond
   // Bounded wait; running out ends the run
   task automatic waitc(input int k);
      int i;
      for (i = 0; i < 200 && cond(k) !== 1'h1; i++)
         hold(1);
      if (i == 200)
      begin
         n_mismatch++;
         $display("BAD %0t wait %0d expired", $time, k);
         print_verdict();
      end
   endtask : waitc
   task automatic t_insert();
      highs = 0;
      lows = 0;
      @(posedge clock);
      insert <= 1'h1;
      waitc(0);
      check(highs > 0 && lows > 0, "no blink while preparing");
      lows = 0;
      hold(12);
      check(lows == 0, "indicator not steady");
   endtask : t_insert
   task automatic t_prohibit_force();
      @(posedge clock);
      removeInsertProhibit <= 1'h1;
      @(posedge clock);
      cardOffButton <= 1'h1;
      lows = 0;
      hold(30);
      check(lows == 0, "button obeyed while prohibited");
      @(posedge clock);
      cardOffButton <= 1'h0;
      forcedDisableRequest <= 1'h1;
      waitc(2);
      check(cardReadyIndicator === 1'h0 && cardAccessEnable === 1'h0, "still on");
      @(posedge clock);
      req <= 6'h3F;
      @(posedge clock);
      req <= 6'h00;
      #1;
      check((err & 6'h3B) === 6'h3B, "late access not refused");
      check(backupErrorCause === `ERR_DISABLED_AFTER, "backup cause");
      check(transferStatus === `ERR_DISABLED_AFTER, "transfer cause");
   endtask : t_prohibit_force
   task automatic t_reinsert();
      @(posedge clock);
      insert <= 1'h0;
      hold(5);
      @(posedge clock);
      insert <= 1'h1;
      highs = 0;
      hold(20);
      check(highs == 0, "lit while disabled");
      @(posedge clock);
      forcedDisableRequest <= 1'h0;
      @(posedge clock);
      forcedDisableRequest <= 1'h1; // Must be dropped: status has not followed yet
      @(posedge clock);
      forcedDisableRequest <= 1'h0;
      waitc(3);
      @(posedge clock);
      insert <= 1'h0;
      removeInsertProhibit <= 1'h0;
      highs = 0;
      hold(12);
      check(highs == 0, "lit with empty slot");
      check(forcedDisableStatus === 1'h0, "early request change obeyed");
      @(posedge clock);
      insert <= 1'h1;
      waitc(0);
   endtask : t_reinsert
   task automatic t_button_stop();
      @(posedge clock);
      startJob <= 1'h1;
      cardOffButton <= 1'h1;
      backupBusy <= 1'h1;
      transferBusy <= 1'h1;
      @(posedge clock);
      startJob <= 1'h0;
      hold(30);
      check(cardAccessEnable === 1'h1, "stopped under a busy job");
      @(posedge clock);
      cardOffButton <= 1'h0;
      backupFileDone <= 1'h1;
      transferFileDone <= 1'h1;
      @(posedge clock);
      backupFileDone <= 1'h0;
      transferFileDone <= 1'h0;
      backupBusy <= 1'h0;
      transferBusy <= 1'h0;
      #1;
      check(err[2] === 1'h1 && backupErrorCause === `ERR_DISABLED_DURING, "backup not cut at file");
      check(err[0] === 1'h1 && transferStatus === `ERR_DISABLED_DURING, "transfer not cut at file");
      check(cardAccessEnable === 1'h1, "stopped under a busy job");
      highs = 0;
      lows = 0;
      waitc(1);
      check(fileInstrBusy === 1'h0, "stop before job end");
      check(highs > 0 && lows > 0 && cardReadyIndicator === 1'h0, "stop indication");
   endtask : t_button_stop
   task automatic t_cassette();
      @(posedge clock);
      cassetteDetect <= 1'h1;
      waitc(4);
      hold(4);
      check(nErase == 1, "no single erase on insertion");
      @(posedge clock);
      capacityMismatch <= 1'h1;
      highs = 0;
      lows = 0;
      repeat (16)
      begin
         @(posedge clock);
         #1;
         if (errorIndicator === 1'h1)
            highs++;
         else
            lows++;
      end
      check(highs > 0 && lows > 0, "error lamp not blinking");
      @(posedge clock);
      capacityMismatch <= 1'h0;
      cassetteDetect <= 1'h0;
      waitc(5);
      hold(4);
      check(nErase == 2 && errorIndicator === 1'h0, "no erase on removal");
   endtask : t_cassette
   initial
   begin
      repeat (20) @(posedge clock);
      reset <= 1'h0;
      t_insert();
      t_prohibit_force();
      t_reinsert();
      t_button_stop();
      t_cassette();
      print_verdict();
   end
endmodule : testbench
